// >>> ftc_timers.sv
// Four timer/counter unit: timers 0..3 with prescalers and counter inputs
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Four 16-bit timers: two general, two reload
// - Timers 0/1: 13-bit, 16-bit, 8-bit reload modes
// - Timers 2/3: 16-bit or dual 8-bit reload
// - Timers 2/3 capture slow clock period
// - Timer 0/1 clock from six sources
// - One shared prescaler, per-timer system bypass
// - Timers 2/3 count sysclk or sysclk/12
// - Timer 2 also RTC/8 or comparator zero
// - Timer 3 also external osc/8 or comparator one
// - Counter mode counts falling edges on pin
// - Counts events up to quarter system clock
// - Overflow flags give periodic interrupt requests
// - Low byte register shows count bits 7:0
// - High byte register shows count bits 15:8
// - Count bytes at 0xcc/0xcd page 0, reset zero
module ftc_timers
  import ftc_pkg::*;
(
  input  wire logic       mclk,            // System clock, 200 MHz
  input  wire logic       nrst,            // Async reset, active low
  input  wire logic [7:0] sfr_addr,        // Special function address
  input  wire logic [3:0] sfr_page,        // Special function page
  input  wire logic       sfr_wr,          // Write strobe
  input  wire logic [7:0] sfr_wdata,       // Write data
  output logic      [7:0] sfr_rdata,       // Read data for timer 2 bytes
  output logic            sfr_hit,         // Address is a timer 2 byte
  input  wire logic [1:0] timer_clock_select_bits, // 1 = system clock
  input  wire logic [1:0] prescale_select_field,   // Shared prescale
  input  wire logic [1:0] t01_counter_mode, // 1 = count pin edges
  input  wire logic [3:0] t01_mode,        // Mode of timer 1 [3:2], 0 [1:0]
  input  wire logic [3:0] t01_run,         // Run: unused, t0 high, t1, t0
  input  wire logic [15:0] t0_load,        // Software write to timer 0
  input  wire logic [15:0] t1_load,        // Software write to timer 1
  input  wire logic [1:0] t01_load_wr,     // Load strobes, timer 1/0
  input  wire logic [1:0] t23_run,         // Run timer 3, timer 2
  input  wire logic [1:0] t23_split,       // Split into two 8-bit timers
  input  wire logic [1:0] t23_capture,     // Capture mode enable
  input  wire logic [3:0] t23_clk_sel,     // Clock source, timer 3 [3:2]
  input  wire logic [15:0] t2_reload,      // Timer 2 reload value
  input  wire logic [15:0] t3_reload,      // Timer 3 reload value
  input  wire logic       event_pin_zero,  // Counter input of timer 0
  input  wire logic       event_pin_one,   // Counter input of timer 1
  input  wire logic       rtc_clock,       // Real-time oscillator
  input  wire logic       external_oscillator_clock, // External oscillator
  input  wire logic       cmp0_out,        // Comparator zero
  input  wire logic       cmp1_out,        // Comparator one
  output logic      [15:0] t0_count,       // Timer 0 count
  output logic      [15:0] t1_count,       // Timer 1 count
  output logic      [15:0] t3_count,       // Timer 3 count
  output logic      [15:0] t23_captured,   // Capture of timer 3 when its capture is on, else timer 2
  output logic      [5:0] ovf_flags        // T3H,T3L,T2H,T2L,T1,T0 flags
);
  // Synchronisers for all asynchronous inputs (6 signals)
  logic [5:0] sync1_ff, sync2_ff, last_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      last_ff  <= 6'h00;
    end else begin
      sync1_ff <= {cmp1_out, cmp0_out, external_oscillator_clock,
                   rtc_clock, event_pin_one, event_pin_zero};
      sync2_ff <= sync1_ff;
      last_ff  <= sync2_ff;
    end
  end
  // Falling edge: previous sample high, current low; a rising edge is
  // used for oscillator and comparator clocks
  logic [1:0] pin_fall;
  logic [3:0] src_rise;
  assign pin_fall = last_ff[1:0] & ~sync2_ff[1:0];
  assign src_rise = ~last_ff[5:2] & sync2_ff[5:2];

  // Divide-by-8 counters on the two oscillators
  logic [2:0] rtc_div_ff, ext_div_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rtc_div_ff <= 3'h0;
      ext_div_ff <= 3'h0;
    end else begin
      if (src_rise[0]) rtc_div_ff <= rtc_div_ff + 3'h1;
      if (src_rise[1]) ext_div_ff <= ext_div_ff + 3'h1;
    end
  end
  logic rtc8_tick, ext8_tick;
  assign rtc8_tick = src_rise[0] && rtc_div_ff == 3'(FTC_DIV8 - 1);
  assign ext8_tick = src_rise[1] && ext_div_ff == 3'(FTC_DIV8 - 1);

  // System clock prescalers: /4, /12, /48
  logic [5:0] pre_ff;
  logic [3:0] div12_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_ff   <= 6'h00;
      div12_ff <= 4'h0;
    end else begin
      pre_ff   <= (pre_ff == 6'(FTC_PRE_DIV48 - 1)) ? 6'h00 : pre_ff + 6'h01;
      div12_ff <= (div12_ff == 4'(FTC_DIV12 - 1)) ? 4'h0 : div12_ff + 4'h1;
    end
  end
  logic tick12, tick4, tick48;
  assign tick12 = div12_ff == 4'(FTC_DIV12 - 1);
  assign tick4  = pre_ff[1:0] == 2'h3;
  assign tick48 = pre_ff == 6'(FTC_PRE_DIV48 - 1);

  // Shared prescaled clock; each timer 0/1 picks it or system clock
  logic pre_tick;
  always_comb begin
    case (prescale_select_field)
      FTC_SCA_DIV12: pre_tick = tick12;
      FTC_SCA_DIV4:  pre_tick = tick4;
      FTC_SCA_DIV48: pre_tick = tick48;
      FTC_SCA_EXT8:  pre_tick = ext8_tick;
      default:       pre_tick = 1'b0;
    endcase
  end
  logic [1:0] t01_tick;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_t01_clk
      // Six sources: four prescaler choices, system clock, or pin
      assign t01_tick[gi] = t01_counter_mode[gi] ? pin_fall[gi] :
        (timer_clock_select_bits[gi] ? 1'b1 : pre_tick);
    end
  endgenerate

  // One 8-bit-half increment helper: returns {carry, next}
  function automatic logic [8:0] ftc_inc8(input logic [7:0] v);
    ftc_inc8 = {1'b0, v} + 9'h001;
  endfunction

  // Timers 0 and 1; timer 1 stops in split mode while timer 0 uses
  // t01_run[2] for the high half
  logic [15:0] t0_ff, t1_ff;
  logic [1:0]  ovf01;
  logic [15:0] nxt_t0, nxt_t1;
  logic [8:0]  lo0, hi0, lo1, hi1;
  always_comb begin
    nxt_t0 = t0_ff;
    nxt_t1 = t1_ff;
    ovf01  = 2'b00;
    lo0 = ftc_inc8(t0_ff[7:0]);
    hi0 = ftc_inc8(t0_ff[15:8]);
    lo1 = ftc_inc8(t1_ff[7:0]);
    hi1 = ftc_inc8(t1_ff[15:8]);
    if (t01_run[0] && t01_tick[0]) begin
      case (t01_mode[1:0])
        FTC_M_13BIT: begin
          nxt_t0[4:0] = t0_ff[4:0] + 5'h01;
          if (t0_ff[4:0] == 5'h1f) begin
            nxt_t0[15:8] = hi0[7:0];
            ovf01[0] = hi0[8];
          end
          nxt_t0[7:5] = 3'h0;
        end
        FTC_M_16BIT: begin
          {ovf01[0], nxt_t0} = {1'b0, t0_ff} + 17'h00001;
        end
        FTC_M_8RLD: begin
          // Low byte wraps to the high byte, which holds the reload
          ovf01[0] = lo0[8];
          nxt_t0[7:0] = lo0[8] ? t0_ff[15:8] : lo0[7:0];
        end
        default: begin
          nxt_t0[7:0] = lo0[7:0];
          ovf01[0] = lo0[8];
        end
      endcase
    end
    // Split mode high half runs on the timer 0 tick and flags t1
    if (t01_mode[1:0] == FTC_M_SPLIT && t01_run[2] && t01_tick[0]) begin
      nxt_t0[15:8] = hi0[7:0];
      ovf01[1] = hi0[8];
    end
    if (t01_mode[1:0] != FTC_M_SPLIT && t01_run[1] && t01_tick[1]) begin
      case (t01_mode[3:2])
        FTC_M_13BIT: begin
          nxt_t1[4:0] = t1_ff[4:0] + 5'h01;
          if (t1_ff[4:0] == 5'h1f) begin
            nxt_t1[15:8] = hi1[7:0];
            ovf01[1] = hi1[8];
          end
          nxt_t1[7:5] = 3'h0;
        end
        FTC_M_16BIT: {ovf01[1], nxt_t1} = {1'b0, t1_ff} + 17'h00001;
        FTC_M_8RLD: begin
          nxt_t1[7:0] = lo1[8] ? t1_ff[15:8] : lo1[7:0];
          ovf01[1] = lo1[8];
        end
        default: nxt_t1 = t1_ff; // Timer 1 has no split mode, holds
      endcase
    end
    if (t01_load_wr[0]) nxt_t0 = t0_load;
    if (t01_load_wr[1]) nxt_t1 = t1_load;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      t0_ff <= FTC_RST_COUNT;
      t1_ff <= FTC_RST_COUNT;
    end else begin
      t0_ff <= nxt_t0;
      t1_ff <= nxt_t1;
    end
  end

  // Timers 2 and 3: clock select, reload, split and capture
  logic [15:0] t23_ff [2];
  logic [15:0] cap_ff [2];
  logic [3:0]  ovf23;
  logic [15:0] nxt_t23 [2];
  logic [1:0]  t23_tick, cap_evt;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_t23
      logic osc_tick, cmp_tick;
      logic [16:0] sum16;
      logic [8:0]  lo, hi;
      assign osc_tick = (gi == 0) ? rtc8_tick : ext8_tick;
      assign cmp_tick = src_rise[2 + gi];
      // Capture mode counts sysclk, or sysclk/12 with DIV12 selected, and latches on the slow source edge
      assign cap_evt[gi] = t23_capture[gi] &&
        (t23_clk_sel[2*gi +: 2] == FTC_C_CMP ? cmp_tick : osc_tick);
      always_comb begin
        case (t23_clk_sel[2*gi +: 2])
          FTC_C_SYS:   t23_tick[gi] = 1'b1;
          FTC_C_DIV12: t23_tick[gi] = tick12;
          FTC_C_OSC8:  t23_tick[gi] = t23_capture[gi] ? 1'b1 : osc_tick;
          FTC_C_CMP:   t23_tick[gi] = t23_capture[gi] ? 1'b1 : cmp_tick;
          default:     t23_tick[gi] = 1'b0;
        endcase
      end
      assign sum16 = {1'b0, t23_ff[gi]} + 17'h00001;
      assign lo = ftc_inc8(t23_ff[gi][7:0]);
      assign hi = ftc_inc8(t23_ff[gi][15:8]);
      always_comb begin
        logic [15:0] rld;
        rld = (gi == 0) ? t2_reload : t3_reload;
        nxt_t23[gi] = t23_ff[gi];
        ovf23[2*gi +: 2] = 2'b00;
        if (t23_run[gi] && t23_tick[gi]) begin
          if (t23_split[gi]) begin
            nxt_t23[gi][7:0]  = lo[8] ? rld[7:0] : lo[7:0];
            nxt_t23[gi][15:8] = hi[8] ? rld[15:8] : hi[7:0];
            ovf23[2*gi +: 2] = {hi[8], lo[8]};
          end else begin
            nxt_t23[gi] = sum16[16] ? rld : sum16[15:0];
            ovf23[2*gi] = sum16[16];
          end
        end
        if (gi == 0 && sfr_wr && sfr_page == FTC_PAGE_T2) begin
          if (sfr_addr == FTC_ADDR_T2_LOW)  nxt_t23[gi][7:0]  = sfr_wdata;
          if (sfr_addr == FTC_ADDR_T2_HIGH) nxt_t23[gi][15:8] = sfr_wdata;
        end
      end
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          t23_ff[gi] <= FTC_RST_COUNT;
          cap_ff[gi] <= FTC_RST_COUNT;
        end else begin
          t23_ff[gi] <= nxt_t23[gi];
          if (cap_evt[gi]) cap_ff[gi] <= t23_ff[gi];
        end
      end
    end
  endgenerate

  // Overflow flags are one-cycle pulses for the interrupt controller
  logic [5:0] ovf_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) ovf_ff <= 6'h00;
    else       ovf_ff <= {ovf23, ovf01};
  end

  // Register read port for the timer 2 count bytes; the page must match
  // too, or a byte on another page would leak the timer value
  logic [7:0] rdata_ff;
  logic       hit;
  assign hit = sfr_page == FTC_PAGE_T2 &&
               (sfr_addr == FTC_ADDR_T2_LOW || sfr_addr == FTC_ADDR_T2_HIGH);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rdata_ff <= FTC_RST_T2_BYTE;
    else if (hit && sfr_addr == FTC_ADDR_T2_LOW)
      rdata_ff <= t23_ff[0][7:0];
    else if (hit && sfr_addr == FTC_ADDR_T2_HIGH)
      rdata_ff <= t23_ff[0][15:8];
    else rdata_ff <= FTC_RST_T2_BYTE;
  end

  assign sfr_rdata    = rdata_ff;
  assign sfr_hit      = hit;
  assign t0_count     = t0_ff;
  assign t1_count     = t1_ff;
  assign t3_count     = t23_ff[1];
  assign t23_captured = t23_capture[1] ? cap_ff[1] : cap_ff[0];
  assign ovf_flags    = ovf_ff;
endmodule
`default_nettype wire

// >>> ftc_pkg.sv
// Package with register map, field codes and timing constants for the timers
package ftc_pkg;
  localparam logic [7:0] FTC_ADDR_T2_LOW  = 8'hcc; // Timer 2 count low byte
  localparam logic [7:0] FTC_ADDR_T2_HIGH = 8'hcd; // Timer 2 count high byte
  localparam logic [3:0] FTC_PAGE_T2      = 4'h0;  // Page of timer 2 bytes
  localparam logic [7:0] FTC_RST_T2_BYTE  = 8'h00; // Count byte reset value
  localparam logic [15:0] FTC_RST_COUNT   = 16'h0000;
  localparam int FTC_DIV12 = 12;                   // Timer 2/3 slow prescale
  localparam int FTC_DIV8  = 8;                    // Oscillator divide
  // Shared prescaler codes of the prescale select field
  localparam logic [1:0] FTC_SCA_DIV12 = 2'h0;
  localparam logic [1:0] FTC_SCA_DIV4  = 2'h1;
  localparam logic [1:0] FTC_SCA_DIV48 = 2'h2;
  localparam logic [1:0] FTC_SCA_EXT8  = 2'h3;
  localparam int FTC_PRE_DIV4  = 4;
  localparam int FTC_PRE_DIV48 = 48;
  // Timer 0/1 operating modes
  localparam logic [1:0] FTC_M_13BIT = 2'h0;
  localparam logic [1:0] FTC_M_16BIT = 2'h1;
  localparam logic [1:0] FTC_M_8RLD  = 2'h2;
  localparam logic [1:0] FTC_M_SPLIT = 2'h3;
  // Timer 2/3 clock sources
  localparam logic [1:0] FTC_C_SYS   = 2'h0;
  localparam logic [1:0] FTC_C_DIV12 = 2'h1;
  localparam logic [1:0] FTC_C_OSC8  = 2'h2;
  localparam logic [1:0] FTC_C_CMP   = 2'h3;
endpackage

// >>> ftc_asserts.sv
// Checker with port-level assertions for the timer unit
`timescale 1ns/1ps
`default_nettype none
module ftc_asserts
  import ftc_pkg::*;
(
  input wire logic        mclk, // System clock
  input wire logic        nrst, // Reset, active low
  input wire logic [7:0]  sfr_addr, // Byte address
  input wire logic [3:0]  sfr_page, // Register page
  input wire logic        sfr_wr, // Write strobe
  input wire logic [7:0]  sfr_wdata, // Write data
  input wire logic [7:0]  sfr_rdata, // Read data
  input wire logic        sfr_hit, // Address match
  input wire logic [1:0]  timer_clock_select_bits, // 1 = system clock
  input wire logic [1:0]  t01_counter_mode, // Pin counting
  input wire logic [3:0]  t01_mode, // Timer 0/1 modes
  input wire logic [3:0]  t01_run, // Run bits
  input wire logic [15:0] t0_load, // Timer 0 load value
  input wire logic [1:0]  t01_load_wr, // Load strobes
  input wire logic [1:0]  t23_run, // Timer 2/3 run
  input wire logic [15:0] t0_count, // Timer 0 count
  input wire logic [5:0]  ovf_flags // Overflow pulses
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Timer 0 ticking every clock with no load pending
  logic t0_go;
  assign t0_go = t01_run[0] && timer_clock_select_bits[0]
                 && !t01_load_wr[0] && !t01_counter_mode[0];
  a_reset_clear: assert property (
    $rose(nrst) |-> t0_count == 16'h0 && sfr_rdata == 8'h0
    && ovf_flags == 6'h0) else $error("outputs not clear after reset");
  a_hit_decode: assert property (
    sfr_hit == (sfr_page == FTC_PAGE_T2 && (sfr_addr == FTC_ADDR_T2_LOW
    || sfr_addr == FTC_ADDR_T2_HIGH))) else $error("address decode wrong");
  a_miss_zero: assert property (
    !sfr_hit |=> sfr_rdata == 8'h0) else $error("unmapped read not zero");
  a_write_read: assert property (
    (sfr_wr && sfr_hit && !t23_run[0]) ##1 (!sfr_wr && !t23_run[0]
    && $stable(sfr_addr) && $stable(sfr_page))
    |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("readback wrong");
  a_load_wins: assert property (
    t01_load_wr[0] |=> t0_count == $past(t0_load)) else $error("no load");
  a_t0_hold: assert property (
    !t01_run[0] && !t01_load_wr[0] && t01_mode[1:0] != FTC_M_SPLIT
    |=> $stable(t0_count)) else $error("stopped timer moved");
  a_t0_step: assert property (
    t0_go && t01_mode[1:0] == FTC_M_16BIT && t0_count != 16'hffff
    |=> t0_count == $past(t0_count) + 16'h1) else $error("missed step");
  a_t0_wrap: assert property (
    t0_go && t01_mode[1:0] == FTC_M_16BIT && t0_count == 16'hffff
    |=> t0_count == 16'h0 ##[0:1] ovf_flags[0]) else $error("no wrap");
  a_t0_reload: assert property (
    t0_go && t01_mode[1:0] == FTC_M_8RLD && t0_count[7:0] == 8'hff
    |=> t0_count[7:0] == $past(t0_count[15:8])) else $error("no reload");
  // Main scenarios reached
  c_wrap: cover property (t0_go && t0_count == 16'hffff);
  c_reload: cover property (t01_mode[1:0] == FTC_M_8RLD && ovf_flags[0]);
  c_readback: cover property (sfr_wr && sfr_hit ##2 sfr_rdata != 8'h0);
endmodule
bind ftc_timers ftc_asserts u_ftc_asserts (.*);
`default_nettype wire

// >>> ftc_partner.sv
// Far-side model: counter pins, oscillators and comparator outputs
`timescale 1ns/1ps
`default_nettype none
module ftc_partner (
  input  wire logic       mclk, // System clock
  input  wire logic       ev_go, // Start a burst of edges
  input  wire logic [3:0] ev_half, // Clocks per pin level
  input  wire logic [7:0] ev_num, // Falling edges per burst
  output logic            ev_busy, // Burst under way
  output logic            event_pin_zero, // Counter input, timer 0
  output logic            event_pin_one, // Counter input, timer 1
  output logic            rtc_clock, // Slow oscillator
  output logic            external_oscillator_clock, // External osc
  output logic            cmp0_out, // Comparator zero
  output logic            cmp1_out // Comparator one
);
  // Pins idle high; sources run free, unrelated in phase to mclk.
  // One process owns every output so no signal has two drivers.
  initial begin
    ev_busy = 1'b0;
    event_pin_zero = 1'b1;
    event_pin_one = 1'b1;
    rtc_clock = 1'b0;
    external_oscillator_clock = 1'b0;
    cmp0_out = 1'b0;
    cmp1_out = 1'b0;
    fork
      forever #7.3 rtc_clock = ~rtc_clock;
      forever #11.1 external_oscillator_clock = ~external_oscillator_clock;
      forever #53.7 cmp0_out = ~cmp0_out;
      forever #61.3 cmp1_out = ~cmp1_out;
      // Each level held ev_half clocks; two or more so none is missed
      forever begin
        @(posedge mclk iff ev_go);
        #1 ev_busy = 1'b1;
        repeat (ev_num) begin
          event_pin_zero = 1'b0;
          event_pin_one = 1'b0;
          repeat (ev_half) @(posedge mclk);
          #1 event_pin_zero = 1'b1;
          event_pin_one = 1'b1;
          repeat (ev_half) @(posedge mclk);
          #1;
        end
        ev_busy = 1'b0;
      end
    join
  end
endmodule
`default_nettype wire

// >>> tb_four_timer_counter_unit.sv
// Self-checking testbench for the four timer/counter unit
`timescale 1ns/1ps
`default_nettype none
module tb_four_timer_counter_unit
  import ftc_pkg::*;
;
  logic mclk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, ev_go = 1'b0;
  logic sfr_hit, ev_busy, event_pin_zero, event_pin_one, rtc_clock;
  logic external_oscillator_clock, cmp0_out, cmp1_out;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, ev_num = 8'h5;
  logic [3:0] sfr_page = '0, t01_mode = '0, t01_run = '0, ev_half = 4'h2;
  logic [3:0] t23_clk_sel = '0;
  logic [1:0] timer_clock_select_bits = '0, prescale_select_field = '0;
  logic [1:0] t01_counter_mode = '0, t01_load_wr = '0, t23_run = '0;
  logic [1:0] t23_split = '0, t23_capture = '0;
  logic [15:0] t0_load = '0, t1_load = '0, t2_reload = '0, t3_reload = '0;
  logic [15:0] t0_count, t1_count, t3_count, t23_captured;
  logic [5:0] ovf_flags;
  int err_total = 0, checks_done = 0;
  ftc_timers u_ftc_timers (.*);
  ftc_partner u_ftc_partner (.mclk(mclk), .ev_go(ev_go), .ev_half(ev_half),
    .ev_num(ev_num), .ev_busy(ev_busy), .event_pin_zero(event_pin_zero),
    .event_pin_one(event_pin_one), .rtc_clock(rtc_clock), .cmp0_out(cmp0_out),
    .external_oscillator_clock(external_oscillator_clock), .cmp1_out(cmp1_out));
  // 200 MHz system clock
  always #2.5 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Inputs always change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] pg, input logic [7:0] a, d);
    sfr_page = pg;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] pg, input logic [7:0] a, d);
    sfr_page = pg;
    sfr_addr = a;
    tick(2);
    chk({24'h0, sfr_rdata}, {24'h0, d});
  endtask
  // Cycles between two fresh overflow pulses; the first only aligns,
  // so a pulse still standing from the previous call is skipped
  task automatic gap(input int b, input int e);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (ovf_flags[b] !== 1'b1 && n < 20000);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (ovf_flags[b] !== 1'b1 && n < 20000);
    chk(n, e);
  endtask
  // Clocks between two captures of a slow source; counter runs at mclk
  task automatic cap(input int t, input logic [1:0] sel, input int lo);
    logic [15:0] c1, d;
    int n;
    t23_capture = 2'(1 << t);
    t23_clk_sel[2*t +: 2] = sel;
    t23_run = 2'(1 << t);
    tick(1);
    for (int k = 0; k < 2; k++) begin
      c1 = t23_captured;
      n = 0;
      while (t23_captured === c1 && n < 200) begin
        tick(1);
        n++;
      end
    end
    d = t23_captured - c1;
    chk(32'(d == 16'(lo) || d == 16'(lo + 1)), 32'h1);
  endtask
  task automatic t0_set(input logic [15:0] v);
    t0_load = v;
    t01_load_wr = 2'b01;
    tick(1);
    t01_load_wr = 2'b00;
  endtask
  task automatic t_regs;
    rd(FTC_PAGE_T2, FTC_ADDR_T2_LOW, FTC_RST_T2_BYTE);
    rd(FTC_PAGE_T2, FTC_ADDR_T2_HIGH, FTC_RST_T2_BYTE);
    wr(FTC_PAGE_T2, FTC_ADDR_T2_LOW, 8'h5a);
    wr(4'h1, FTC_ADDR_T2_LOW, 8'h33);
    wr(FTC_PAGE_T2, 8'hce, 8'h11);
    rd(FTC_PAGE_T2, FTC_ADDR_T2_LOW, 8'h5a);
    rd(FTC_PAGE_T2, 8'hce, 8'h00);
    rd(4'h1, FTC_ADDR_T2_LOW, 8'h00);
    wr(FTC_PAGE_T2, FTC_ADDR_T2_HIGH, 8'ha5);
    rd(FTC_PAGE_T2, FTC_ADDR_T2_HIGH, 8'ha5);
    $display("test registers done");
  endtask
  // Reload period gives the count span and the tick rate
  task automatic t_reload;
    wr(FTC_PAGE_T2, FTC_ADDR_T2_LOW, 8'hfa);
    wr(FTC_PAGE_T2, FTC_ADDR_T2_HIGH, 8'hff);
    t2_reload = 16'hfffa;
    t23_run = 2'b01;
    gap(2, 6);
    t23_clk_sel[1:0] = FTC_C_DIV12;
    t2_reload = 16'hfffe;
    gap(2, 2 * FTC_DIV12);
    t23_run = 2'b10;
    t23_split = 2'b10;
    t3_reload = 16'hfcf8;
    gap(4, 8);
    gap(5, 4);
    t23_run = 2'b00;
    $display("test reload done");
  endtask
  // Window of 96 clocks holds a whole number of prescaled ticks
  task automatic t_pre;
    int dv [4] = '{FTC_DIV12, FTC_PRE_DIV4, FTC_PRE_DIV48, 1};
    t01_mode = {FTC_M_16BIT, FTC_M_16BIT};
    for (int i = 0; i < 4; i++) begin
      prescale_select_field = 2'(i % 3);
      timer_clock_select_bits = {1'b0, i == 3};
      t0_set(16'hfffe);
      t01_run = 4'h1;
      tick(96);
      t01_run = 4'h0;
      tick(2);
      chk(t0_count, 16'(16'hfffe + 96 / dv[i]));
    end
    $display("test prescaler done");
  endtask
  task automatic t_modes;
    timer_clock_select_bits = 2'b11;
    t01_mode = {FTC_M_SPLIT, FTC_M_8RLD};
    t0_set(16'hfcfc);
    t01_run = 4'h3;
    gap(0, 4);
    t01_mode[1:0] = FTC_M_13BIT;
    gap(0, 8192);
    t01_mode[1:0] = FTC_M_SPLIT;
    t01_run = 4'h6;
    gap(1, 256);
    chk(t1_count, 16'h0);
    t01_run = 4'h0;
    $display("test modes done");
  endtask
  // Pin edges at a quarter of the clock rate on both counters
  task automatic t_count;
    int n;
    t01_mode = {FTC_M_16BIT, FTC_M_16BIT};
    t01_counter_mode = 2'b11;
    t0_set(16'h0);
    t01_run = 4'h3;
    ev_go = 1'b1;
    tick(1);
    ev_go = 1'b0;
    tick(1);
    n = 0;
    while (ev_busy !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    tick(6);
    chk(t0_count, 16'h5);
    chk(t1_count, 16'h5);
    $display("test counters done");
  endtask
  // Source periods of the partner: rtc 14.6 ns, ext 22.2 ns, comparators
  // 107.4 ns and 122.6 ns, so eight-cycle spans are fractional clocks
  task automatic t_cap;
    logic [15:0] c;
    t2_reload = 16'h0000;
    t3_reload = 16'h0000;
    t23_split = 2'b00;
    cap(0, FTC_C_OSC8, 23);
    cap(0, FTC_C_CMP, 21);
    cap(1, FTC_C_OSC8, 35);
    cap(1, FTC_C_CMP, 24);
    c = t3_count;
    tick(20);
    chk(t3_count, 16'(c + 16'h0014));
    t23_run = 2'b00;
    t23_capture = 2'b00;
    // Shared prescaler fed by external oscillator over eight
    t01_counter_mode = 2'b00;
    timer_clock_select_bits = 2'b00;
    prescale_select_field = FTC_SCA_EXT8;
    t01_mode = {FTC_M_16BIT, FTC_M_16BIT};
    t0_set(16'h0000);
    t01_run = 4'h1;
    tick(360);
    t01_run = 4'h0;
    c = t0_count;
    chk(32'(c == 16'h000a || c == 16'h000b), 32'h1);
    $display("test capture done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog: the run needs about 10k clocks
  initial begin
    #300000;
    err_total++;
    results();
  end
  // Reset for 4 clocks, then the scenarios
  initial begin
    tick(4);
    nrst = 1'b1;
    t_regs();
    t_reload();
    t_pre();
    t_modes();
    t_count();
    t_cap();
    results();
  end
endmodule
`default_nettype wire
